/* core/event_timer.sv */
// second event counter with scheduled output unit
`default_nettype none
// What this block does
// R1: pin rising edge clears second counter
// R2: command clears second counter on match
// R3: modulo via commands uses one store entry, reloaded after each match
// R4: capture input zero may reset counter
// R5: capture input zero has own interrupt
// R6: capture input one may clock counter
// R7: command encodes timer, action, pin
// R8: low command bits select the pin
// R9: event executes when timer equals time
// R10: software polls busy bit six first
// R11: software spaces loads eight states apart
// R12: software writes command before time
module event_timer (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic external_count_clock_pin,
    input wire logic external_count_reset_pin,
    input wire logic capture0_pin,
    input wire logic capture1_pin,
    input wire logic clock_source_sel,
    input wire logic reset_source_sel,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_data,
    input wire logic time_write,
    input wire logic [15:0] time_data,
    output logic [15:0] free_running_timer,
    output logic [15:0] timer2,
    output logic [7:0] output_status_register,
    output logic [5:0] scheduled_pins,
    output logic capture0_irq,
    output logic event_irq
);
    // wires to the match store; the store owns compare and retire
    match_store_if ms();
    event_timer_pkg::source_type clk_src; // counter clock source
    event_timer_pkg::source_type rst_src; // counter reset source
    logic [3:0] sync_a;                   // first sync stage, feeds b only
    logic [3:0] sync_b;                   // second sync stage
    logic [3:0] sync_c;                   // delayed copy for edges
    logic [7:0] output_event_command;     // command byte latch
    logic hold_full;                      // holding register busy
    logic [7:0] hold_cmd;                 // held command
    logic [15:0] hold_time;               // held event time
    logic [3:0] load_count;               // transfer delay counter
    logic clk_rise;                       // counter clock edge
    logic rst_rise;                       // counter reset edge
    logic cap0_rise;                      // capture zero edge
    logic match_reset;                    // store reset of counter
    logic [3:0] fire_pin;                 // pin of matched entry

    // source selects are levels from logic on this clock, so they need
    // no synchroniser; edges are found on each pin before the select,
    // so switching them never makes a stray edge
    assign clk_src = clock_source_sel ? event_timer_pkg::src_capture
        : event_timer_pkg::src_pin;
    assign rst_src = reset_source_sel ? event_timer_pkg::src_capture
        : event_timer_pkg::src_pin;

    // pins are asynchronous to sys_clk; two stages settle them
    // two flops per pin; stage a feeds only stage b
    // a third flop keeps the previous sample for the edge detectors
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
            sync_c <= 4'h0;
        end else begin
            sync_a <= {capture1_pin, capture0_pin,
                external_count_reset_pin, external_count_clock_pin};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // capture zero edge, shared by the interrupt and the reset mux
    assign cap0_rise = sync_b[2] && !sync_c[2];
    // pick the counter clock edge
    assign clk_rise = (clk_src == event_timer_pkg::src_capture) ?
        (sync_b[3] && !sync_c[3]) : (sync_b[0] && !sync_c[0]); // R6
    // pick the counter reset edge
    assign rst_rise = (rst_src == event_timer_pkg::src_capture) ?
        cap0_rise : (sync_b[1] && !sync_c[1]); // R1 R4
    // pin code of the entry that fired this cycle
    assign fire_pin = ms.fire_cmd[event_timer_pkg::cmd_pin_lsb +:
        event_timer_pkg::cmd_pin_width]; // R8
    // a fired entry carrying the reserved reset code clears the second
    // counter; the entry retires, so a repeat needs a software reload
    assign match_reset = ms.fire &&
        (fire_pin == event_timer_pkg::pin_reset_timer2); // R2 R3

    // free running timer counts every clock
    // it wraps at the top; event times wrap with it, so any time from ten counts
    // past the timer in the time write cycle up to the full range can be scheduled
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            free_running_timer <= event_timer_pkg::timer_reset;
        end else begin
            free_running_timer <= free_running_timer + 16'h0001;
        end
    end

    // second counter; a reset beats a count in the same cycle
    // pin edges act three clocks after the pin rises, a store reset
    // two clocks after the match; both delays are fixed
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            timer2 <= event_timer_pkg::timer_reset;
        end else if (rst_rise || match_reset) begin
            timer2 <= event_timer_pkg::timer_reset; // R1 R2 R4
        end else if (clk_rise) begin
            timer2 <= timer2 + 16'h0001; // R6
        end
    end

    // capture zero interrupt pulse, regardless of reset source
    // raised even when capture zero also resets the counter, so
    // software can still run a task once per revolution
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            capture0_irq <= 1'b0;
        end else begin
            capture0_irq <= cap0_rise; // R5
        end
    end

    // command byte is latched; the time write commits both
    // writing the command alone never schedules anything, which lets
    // software prepare the command well ahead of the time
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            output_event_command <= 8'h00;
        end else if (cmd_write) begin
            output_event_command <= cmd_data; // R7
        end
    end

    // holding register; a write while busy overwrites it
    // the transfer delay gives the store its load slot; a second time
    // write inside it replaces the held event, hence the busy poll
    // a full store keeps the event here and busy stays high
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hold_full <= 1'b0;
            hold_cmd <= 8'h00;
            hold_time <= event_timer_pkg::timer_reset;
            load_count <= 4'h0;
        end else if (time_write) begin
            hold_full <= 1'b1; // R12
            hold_cmd <= output_event_command;
            hold_time <= time_data;
            load_count <= event_timer_pkg::load_cycles_count; // R11
        end else if (hold_full) begin
            // count down the transfer delay first
            if (load_count != 4'h0) begin
                load_count <= load_count - 4'h1;
            end else if (!ms.store_full) begin
                hold_full <= 1'b0; // moved into the store
            end
        end
    end

    // the store sees a load only once the delay has run out
    // both timers go to the store; each entry picks one by its command
    assign ms.load_valid = hold_full && (load_count == 4'h0);
    assign ms.load_cmd = hold_cmd;
    assign ms.load_time = hold_time;
    assign ms.free_running_timer_now = free_running_timer;
    assign ms.timer2_now = timer2;

    // the match store keeps its own entry table and retires one entry
    // per clock; of simultaneous matches the lowest index fires, the rest in a later clock in which they match
    match_store store_inst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .bus(ms.store)
    );

    // matched events drive pins; set bit picks level
    // codes six and above are not pins; the reset code is handled
    // above and the other codes leave the pins alone
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            scheduled_pins <= 6'h00;
        end else if (ms.fire &&
            fire_pin < 4'(event_timer_pkg::pin_count)) begin
            scheduled_pins[fire_pin[2:0]] <=
                ms.fire_cmd[event_timer_pkg::cmd_set_bit]; // R9
        end
    end

    // event interrupt when the command asks for it
    // the request bit sits inside the pin field, so some pin codes
    // always interrupt; the logic reads bit 2, two below cmd_always_bit
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            event_irq <= 1'b0;
        end else begin
            event_irq <= ms.fire &&
                ms.fire_cmd[event_timer_pkg::cmd_always_bit - 2];
        end
    end

    // status: busy bit plus pin levels in the low bits
    // pins show as they stood one clock earlier, since the status
    // byte is registered from the registered pins
    // busy includes the write cycle itself, so a poll right after
    // the write already sees it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            output_status_register <= event_timer_pkg::status_reset;
        end else begin
            output_status_register <= {1'b0, hold_full || time_write,
                scheduled_pins}; // R10
        end
    end
endmodule : event_timer
`default_nettype wire

/* core/event_timer_pkg.sv */
// constants and types shared by the event timer and its match store
`default_nettype none
package event_timer_pkg;
    localparam int timer_width = 16;
    localparam int cmd_width = 8;
    localparam int pin_count = 6;
    localparam int store_depth = 8;
    // command byte fields
    localparam int cmd_timer2_bit = 6;
    localparam int cmd_set_bit = 5;
    localparam int cmd_always_bit = 4;
    localparam int cmd_pin_lsb = 0;
    localparam int cmd_pin_width = 4;
    // this pin number is the one internal action: it clears the second counter
    localparam logic [3:0] pin_reset_timer2 = 4'he;
    // documented example commands
    localparam logic [7:0] cmd_set_pin0 = 8'h30;
    localparam logic [7:0] cmd_clear_pin0 = 8'h10;
    localparam logic [7:0] cmd_set_pin1 = 8'h31;
    localparam logic [7:0] cmd_clear_pin1 = 8'h11;
    // status byte layout
    localparam int status_busy_bit = 6;
    localparam logic [7:0] status_reset = 8'h00;
    localparam logic [15:0] timer_reset = 16'h0000;
    // holding register to store transfer time
    localparam int load_time_ns = 800;
    localparam int clock_period_ns = 100;
    localparam int load_cycles = (load_time_ns + clock_period_ns - 1)
        / clock_period_ns;
    localparam logic [3:0] load_cycles_count = 4'(load_cycles);
    typedef enum logic {src_pin, src_capture} source_type;
endpackage : event_timer_pkg
`default_nettype wire

/* core/match_store.sv */
// event match store: pending commands compared to the timers
`default_nettype none
module match_store (
    input wire logic sys_clk,
    input wire logic resetn,
    match_store_if.store bus
);
    localparam int depth = event_timer_pkg::store_depth;
    logic [depth-1:0] used;              // entry holds an event
    logic [7:0] cmd [depth];             // stored commands
    logic [15:0] when [depth];           // stored times
    logic [depth-1:0] hit;               // entry matches now
    logic [$clog2(depth)-1:0] free_idx;  // lowest free entry
    logic [$clog2(depth)-1:0] hit_idx;   // lowest matching entry
    logic any_hit;                       // some entry matches

    // compare each used entry to the timer it selects
    always_comb begin
        for (int i = 0; i < depth; i++) begin
            hit[i] = used[i] && (when[i] ==
                (cmd[i][event_timer_pkg::cmd_timer2_bit] ?
                bus.timer2_now : bus.free_running_timer_now));
        end
    end

    // priority picks: lowest index wins
    always_comb begin
        free_idx = '0;
        hit_idx = '0;
        any_hit = 1'b0;
        for (int i = depth - 1; i >= 0; i--) begin
            if (!used[i]) begin
                free_idx = ($clog2(depth))'(i);
            end
            if (hit[i]) begin
                hit_idx = ($clog2(depth))'(i);
                any_hit = 1'b1;
            end
        end
    end

    assign bus.store_full = &used;

    // one entry retires per cycle; others wait for the next compare
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            used <= '0;
        end else begin
            if (any_hit) begin
                used[hit_idx] <= 1'b0;
            end
            if (bus.load_valid && !bus.store_full) begin
                used[free_idx] <= 1'b1;
            end
        end
    end

    // entry contents, no reset needed behind the used flags
    always_ff @(posedge sys_clk) begin
        if (bus.load_valid && !bus.store_full) begin
            cmd[free_idx] <= bus.load_cmd;
            when[free_idx] <= bus.load_time;
        end
    end

    // registered match output
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bus.fire <= 1'b0;
            bus.fire_cmd <= 8'h00;
        end else begin
            bus.fire <= any_hit;
            bus.fire_cmd <= any_hit ? cmd[hit_idx] : 8'h00;
        end
    end
endmodule : match_store
`default_nettype wire

/* core/match_store_if.sv */
// wires between the event timer and its match store
`default_nettype none
interface match_store_if;
    logic load_valid;           // write a new entry
    logic [7:0] load_cmd;       // command of the entry
    logic [15:0] load_time;     // match time of the entry
    logic store_full;           // no free entry
    logic [15:0] free_running_timer_now;    // free running time
    logic [15:0] timer2_now;    // second counter time
    logic fire;                 // one entry matched the cycle before
    logic [7:0] fire_cmd;       // command of the matched entry
    modport top(output load_valid, load_cmd, load_time, free_running_timer_now,
        timer2_now, input store_full, fire, fire_cmd);
    modport store(input load_valid, load_cmd, load_time, free_running_timer_now,
        timer2_now, output store_full, fire, fire_cmd);
endinterface : match_store_if
`default_nettype wire

/* test/event_timer_checker.sv */
// concurrent checks on the event timer top ports
`default_nettype none
module event_timer_checker (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic external_count_clock_pin,
    input wire logic external_count_reset_pin,
    input wire logic capture0_pin,
    input wire logic capture1_pin,
    input wire logic clock_source_sel,
    input wire logic reset_source_sel,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_data,
    input wire logic time_write,
    input wire logic [15:0] time_data,
    input wire logic [15:0] free_running_timer,
    input wire logic [15:0] timer2,
    input wire logic [7:0] output_status_register,
    input wire logic [5:0] scheduled_pins,
    input wire logic capture0_irq,
    input wire logic event_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // one domain, so one clock and one disable
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // the first clock after reset release still shows the reset value
    frt_step_a: assert property ($past(resetn) |->
        free_running_timer == $past(free_running_timer) + 16'h1)
        else $error("timer step");
    busy_set_a: assert property (time_write |=>
        output_status_register[6]) else $error("busy not set");
    // holding register drains into the store after eight cycles
    busy_hold_a: assert property ($rose(output_status_register[6]) |->
        output_status_register[6] [*8] ##[1:4] !output_status_register[6])
        else $error("busy length");
    // status pins are registered from the registered pins, one clock late
    pins_mirror_a: assert property (output_status_register[5:0] ==
        $past(scheduled_pins)) else $error("status pins");
    rst_pin_a: assert property (!reset_source_sel &&
        $rose(external_count_reset_pin) |-> ##[1:5] timer2 == 16'h0)
        else $error("reset pin");
    cap_reset_a: assert property (reset_source_sel &&
        $rose(capture0_pin) |-> ##[1:5] timer2 == 16'h0)
        else $error("capture reset");
    cap_irq_a: assert property ($rose(capture0_pin) |->
        ##[1:5] capture0_irq) else $error("capture irq");
    irq_pulse_a: assert property (capture0_irq |=> !capture0_irq)
        else $error("irq width");
    // the second counter only steps by one or clears
    t2_step_a: assert property ($changed(timer2) |->
        (timer2 == $past(timer2) + 16'h1) || (timer2 == 16'h0))
        else $error("counter step");
    cover property ($rose(scheduled_pins[0]));
    cover property (capture0_irq);
    cover property ($fell(output_status_register[6]));
    cover property (event_irq);
endmodule : event_timer_checker
bind event_timer event_timer_checker checker_i (.sys_clk, .resetn,
    .external_count_clock_pin, .external_count_reset_pin, .capture0_pin,
    .capture1_pin, .clock_source_sel, .reset_source_sel, .cmd_write,
    .cmd_data, .time_write, .time_data, .free_running_timer, .timer2,
    .output_status_register, .scheduled_pins, .capture0_irq, .event_irq);
`default_nettype wire

/* test/event_timer_test.sv */
// self-checking bench for the event timer
`default_nettype none
`define chk(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
    $display("BAD %0t %h %h", $time, a, e); end end
module event_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, resetn, clock_source_sel, reset_source_sel;
    logic cmd_write, time_write, capture0_irq, event_irq;
    logic [7:0] cmd_data, output_status_register;
    logic [15:0] time_data, free_running_timer, timer2;
    logic [5:0] scheduled_pins;
    logic [3:0] pins; // 0 clock, 1 reset, 2 capture0, 3 capture1
    int failures, num_checks, cycles, irqs, evs;
    event_timer dut (.sys_clk(sys_clk), .resetn(resetn),
        .external_count_clock_pin(pins[0]),
        .external_count_reset_pin(pins[1]), .capture0_pin(pins[2]),
        .capture1_pin(pins[3]), .clock_source_sel(clock_source_sel),
        .reset_source_sel(reset_source_sel), .cmd_write(cmd_write),
        .cmd_data(cmd_data), .time_write(time_write),
        .time_data(time_data), .free_running_timer(free_running_timer),
        .timer2(timer2), .output_status_register(output_status_register),
        .scheduled_pins(scheduled_pins), .capture0_irq(capture0_irq),
        .event_irq(event_irq));
    sensor_model sensor (.sys_clk(sys_clk), .pins(pins));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // cycle ceiling and a tally of one-cycle capture and event interrupts
    always @(posedge sys_clk) begin
        cycles++;
        if (capture0_irq === 1'b1) irqs++;
        if (event_irq === 1'b1) evs++;
        if (cycles == 5000) begin
            failures++;
            end_sim();
        end
    end
    task end_sim;
        if (failures == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // poll busy, command byte first, time second, then space loads apart
    task load(input logic [7:0] c, input logic [15:0] t);
        int n;
        n = 0;
        while (output_status_register[6] !== 1'b0 && n < 50) begin
            tick(1);
            n++;
        end
        cmd_write = 1'b1;
        cmd_data = c;
        tick(1);
        cmd_write = 1'b0;
        time_write = 1'b1;
        time_data = t;
        tick(1);
        time_write = 1'b0;
        `chk(output_status_register[6], 1'b1)
        tick(9);
    endtask : load
    task t_free;
        logic [15:0] s;
        s = free_running_timer;
        tick(10);
        `chk(free_running_timer, s + 16'ha)
    endtask : t_free
    // clock pin counts, capture1 ignored, then the select swaps them
    task t_count;
        logic [15:0] s;
        s = timer2;
        sensor.pulse(0, 5);
        sensor.pulse(3, 2);
        tick(6);
        `chk(timer2, s + 16'h5)
        clock_source_sel = 1'b1;
        sensor.pulse(0, 2);
        sensor.pulse(3, 3);
        tick(6);
        `chk(timer2, s + 16'h8)
        clock_source_sel = 1'b0;
    endtask : t_count
    task t_reset;
        int s;
        `chk(timer2 == 16'h0, 1'b0)
        sensor.pulse(1, 1);
        tick(3);
        `chk(timer2, 16'h0)
        sensor.pulse(0, 2);
        s = irqs;
        sensor.pulse(2, 1); // not the reset source yet
        tick(6);
        `chk(timer2, 16'h2)
        `chk(irqs, s + 1)
        reset_source_sel = 1'b1;
        sensor.pulse(2, 1);
        tick(6);
        `chk(timer2, 16'h0)
        `chk(irqs, s + 2)
        reset_source_sel = 1'b0;
    endtask : t_reset
    // the four example commands, each must land at its time
    task t_sched;
        logic [7:0] cmds [4];
        logic [5:0] want [4];
        logic [15:0] t;
        int i, n, e;
        cmds = '{event_timer_pkg::cmd_set_pin0, event_timer_pkg::cmd_set_pin1,
            event_timer_pkg::cmd_clear_pin0, event_timer_pkg::cmd_clear_pin1};
        want = '{6'h01, 6'h03, 6'h02, 6'h00};
        e = evs;
        for (i = 0; i < 4; i++) begin
            t = free_running_timer + 16'h20;
            load(cmds[i], t);
            n = 0;
            while (scheduled_pins !== want[i] && n < 80) begin
                tick(1);
                n++;
            end
            `chk(scheduled_pins, want[i])
            `chk(free_running_timer - t <= 16'h4, 1'b1)
            // status pins follow the pins one clock later
            tick(1);
            `chk(output_status_register[5:0], want[i])
        end
        // all four set cmd_always_bit, but bit 2 is clear in each, so none interrupts
        `chk(evs, e)
    endtask : t_sched
    // second-timer match on the reset code clears the counter once, at four
    task t_modulo;
        int s;
        s = evs;
        load(8'h5e, 16'h0004); // timer2 select, counter reset code
        sensor.pulse(0, 4);
        tick(4);
        `chk(timer2, 16'h0)
        `chk(evs, s + 1)
        sensor.pulse(0, 1);
        tick(4);
        `chk(timer2, 16'h1)
        // the reset entry has retired: no second wrap without a reload
        sensor.pulse(0, 4);
        tick(4);
        `chk(timer2, 16'h5)
    endtask : t_modulo
    initial begin
        resetn = 1'b0;
        clock_source_sel = 1'b0;
        reset_source_sel = 1'b0;
        cmd_write = 1'b0;
        cmd_data = 8'h00;
        time_write = 1'b0;
        time_data = 16'h0000;
        tick(3);
        resetn = 1'b1;
        `chk(timer2, event_timer_pkg::timer_reset)
        `chk(free_running_timer, event_timer_pkg::timer_reset)
        `chk(output_status_register, event_timer_pkg::status_reset)
        `chk({scheduled_pins, capture0_irq, event_irq}, 8'h00)
        t_free();
        t_count();
        t_reset();
        t_sched();
        t_modulo();
        end_sim();
    end
endmodule : event_timer_test
`default_nettype wire

/* test/sensor_model.sv */
// pulse sensor model on the count and capture pins
`default_nettype none
module sensor_model (
    input wire logic sys_clk,
    output logic [3:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle lines sit low between teeth
    initial pins = 4'h0;
    // n teeth on one line, slow enough for the two-flop synchroniser
    task pulse(input int line, input int n);
        repeat (n) begin
            repeat (3) @(posedge sys_clk);
            #1;
            pins[line[1:0]] = 1'b1;
            repeat (3) @(posedge sys_clk);
            #1;
            pins[line[1:0]] = 1'b0;
        end
    endtask : pulse
endmodule : sensor_model
`default_nettype wire
